// ==== hw/qcr_bank.sv ====
// one channel's set of read/write registers
// assumes: write strobe already decoded for the selected channel
`timescale 1ns/100ps
module qcr_bank (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic [4:0] slot_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem_r [0:26];
	logic [7:0] mem_nxt [0:26];
	always_comb begin
		for (int i = 0; i < 27; i++) begin
			mem_nxt[i] = mem_r[i];
		end
		if (we_i && slot_i < 5'd27) begin
			mem_nxt[slot_i] = wdata_i;
		end
	end
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 27; i++) begin
			mem_r[i] <= rst_i ? 8'h00 : mem_nxt[i];
		end
	end
	assign rdata_o = (slot_i < 5'd27) ? mem_r[slot_i] : 8'h00;
endmodule

// ==== hw/qcr_cfg.svh ====
// register offsets, field positions and slot count of the quad channel register decoder
// assumes: included by design and testbench files, by bare name
`ifndef QCR_CFG_SVH
`define QCR_CFG_SVH
`define QCR_CHAN_CMD 7'h05
`define QCR_SRV_REQ_EN 7'h06
`define QCR_OPT_1 7'h08
`define QCR_OPT_2 7'h09
`define QCR_OPT_3 7'h0A
`define QCR_CTL_STAT 7'h0B
`define QCR_RX_COUNT 7'h0E
`define QCR_MDM_OPT_1 7'h15
`define QCR_MDM_OPT_2 7'h16
`define QCR_LOC_VEC 7'h18
`define QCR_SPC_1 7'h1A
`define QCR_SPC_2 7'h1B
`define QCR_SPC_3 7'h1C
`define QCR_SPC_4 7'h1D
`define QCR_OPT_4 7'h1E
`define QCR_OPT_5 7'h1F
`define QCR_RX_TMO 7'h21
`define QCR_RNG_LO 7'h22
`define QCR_RNG_HI 7'h23
`define QCR_LIT_NEXT 7'h24
`define QCR_FW_REV 7'h40
`define QCR_MDM_VEC 7'h41
`define QCR_TX_VEC 7'h42
`define QCR_RX_VEC 7'h43
`define QCR_RX_SVC_CH 7'h44
`define QCR_TX_SVC_CH 7'h45
`define QCR_MDM_SVC_CH 7'h46
`define QCR_GLB_CFG 7'h4B
`define QCR_MDM_STAT 7'h4C
`define QCR_END_SVC 7'h60
`define QCR_RX_DATA 7'h62
`define QCR_TX_DATA 7'h63
`define QCR_SVC_SUM 7'h67
`define QCR_CHAN_SEL 7'h68
`define QCR_MDM_ACK 7'h69
`define QCR_TX_ACK 7'h6A
`define QCR_RX_ACK 7'h6B
`define QCR_MSV_1 7'h6C
`define QCR_MSV_2 7'h6D
`define QCR_PRN_SV 7'h6F
`define QCR_TX_RATE 7'h72
`define QCR_TX_CLK 7'h76
`define QCR_RX_RATE 7'h78
`define QCR_RX_CLK 7'h7C
`define QCR_PRESCALE 7'h7E
// global config bit 7: channel 0 parallel mode when set
`define QCR_GCR_PAR_BIT 7
// wishbone offsets of the host end
`define QCR_WB_ADDR 5'h00
`define QCR_WB_WDATA 5'h04
`define QCR_WB_CMD 5'h08
`define QCR_WB_RDATA 5'h0C
`define QCR_WB_IRQ_ST 5'h10
`define QCR_WB_IRQ_MSK 5'h14
`define QCR_WB_STATUS 5'h18
`define QCR_SLOT_CNT 6'd27
`endif

// ==== hw/qcr_dev.sv ====
// device end: decodes 7-bit offsets into global, virtual and banked channel registers
// assumes: host end keeps one request standing until ack; svc_act marks a service routine
`timescale 1ns/100ps
`include "qcr_cfg.svh"
module qcr_dev (
	input wire logic clk_i,
	input wire logic rst_i,
	qcr_if.dev bus,
	input wire logic [7:0] rx_vec_i,
	input wire logic [7:0] tx_vec_i,
	input wire logic [7:0] mdm_vec_i,
	input wire logic [7:0] mdm_stat_i,
	input wire logic [7:0] rx_data_i,
	input wire logic [7:0] svc_sum_i,
	input wire logic [31:0] ctl_stat_i,
	input wire logic [31:0] rx_count_i,
	output logic [1:0] chan_sel_o,
	output logic par_mode_o,
	output logic [7:0] tx_data_o,
	output logic tx_data_stb_o,
	output logic end_svc_stb_o,
	output logic [7:0] read_stb_o
);
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	qcr_pkg::qcr_kind_t kind;
	logic [4:0] slot;
	logic is_gl_rw;
	logic [3:0] gl_idx;
	logic req;
	logic [1:0] chan_r;
	logic [7:0] bank_rd [0:3];
	logic [3:0] bank_we;
	logic [7:0] glb_r [0:9];
	logic [7:0] glb_nxt [0:9];
	logic [7:0] rd_val;
	logic [7:0] rdata_r, rdata_nxt;
	logic ack_r, ack_nxt;
	logic [7:0] txd_r, txd_nxt;
	logic txs_r, txs_nxt, eos_r, eos_nxt;
	logic [7:0] rstb_r, rstb_nxt;
	logic [1:0] chan_nxt;

	assign req = bus.cs && !ack_r;

	// slot of a banked read/write register, 1F when the offset is none
	always_comb begin
		unique case (bus.addr)
			`QCR_CHAN_CMD: slot = 5'h00;
			`QCR_SRV_REQ_EN: slot = 5'h01;
			`QCR_OPT_1: slot = 5'h02;
			`QCR_OPT_2: slot = 5'h03;
			`QCR_OPT_3: slot = 5'h04;
			`QCR_OPT_4: slot = 5'h05;
			`QCR_OPT_5: slot = 5'h06;
			`QCR_MDM_OPT_1: slot = 5'h07;
			`QCR_MDM_OPT_2: slot = 5'h08;
			`QCR_LOC_VEC: slot = 5'h09;
			`QCR_SPC_1: slot = 5'h0A;
			`QCR_SPC_2: slot = 5'h0B;
			`QCR_SPC_3: slot = 5'h0C;
			`QCR_SPC_4: slot = 5'h0D;
			`QCR_RX_TMO: slot = 5'h0E;
			`QCR_RNG_LO: slot = 5'h0F;
			`QCR_RNG_HI: slot = 5'h10;
			`QCR_LIT_NEXT: slot = 5'h11;
			`QCR_MSV_1: slot = 5'h12;
			`QCR_MSV_2: slot = 5'h13;
			`QCR_PRN_SV: slot = 5'h14;
			`QCR_TX_RATE: slot = 5'h15;
			`QCR_TX_CLK: slot = 5'h16;
			`QCR_RX_RATE: slot = 5'h17;
			`QCR_RX_CLK: slot = 5'h18;
			default: slot = 5'h1F;
		endcase
	end

	// index of a global read/write register
	always_comb begin
		is_gl_rw = 1'b1;
		unique case (bus.addr)
			`QCR_FW_REV: gl_idx = 4'h0;
			`QCR_CHAN_SEL: gl_idx = 4'h1;
			`QCR_GLB_CFG: gl_idx = 4'h2;
			`QCR_RX_SVC_CH: gl_idx = 4'h3;
			`QCR_TX_SVC_CH: gl_idx = 4'h4;
			`QCR_MDM_SVC_CH: gl_idx = 4'h5;
			`QCR_RX_ACK: gl_idx = 4'h6;
			`QCR_TX_ACK: gl_idx = 4'h7;
			`QCR_MDM_ACK: gl_idx = 4'h8;
			`QCR_PRESCALE: gl_idx = 4'h9;
			default: begin
				is_gl_rw = 1'b0;
				gl_idx = 4'h0;
			end
		endcase
	end

	// kind of register behind the offset
	always_comb begin
		unique case (bus.addr)
			`QCR_SVC_SUM: kind = qcr_pkg::QCR_KIND_GLOBAL;
			`QCR_RX_VEC, `QCR_TX_VEC, `QCR_MDM_VEC, `QCR_MDM_STAT: kind = qcr_pkg::QCR_KIND_VIRTUAL;
			`QCR_END_SVC, `QCR_TX_DATA, `QCR_RX_DATA: kind = qcr_pkg::QCR_KIND_VIRTUAL;
			`QCR_CTL_STAT, `QCR_RX_COUNT: kind = qcr_pkg::QCR_KIND_CHANNEL;
			default: begin
				if (is_gl_rw) begin
					kind = qcr_pkg::QCR_KIND_GLOBAL;
				end else if (slot != 5'h1F) begin
					kind = qcr_pkg::QCR_KIND_CHANNEL;
				end else begin
					kind = qcr_pkg::QCR_KIND_NONE;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// channel banks
	// ------------------------------------------------------------
	for (genvar c = 0; c < 4; c++) begin : g_bank
		// only the selected bank sees the write
		assign bank_we[c] = req && bus.wr && kind == qcr_pkg::QCR_KIND_CHANNEL && chan_r == 2'(c);
		qcr_bank u_bank (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.we_i(bank_we[c]),
			.slot_i(slot),
			.wdata_i(bus.wdata),
			.rdata_o(bank_rd[c])
		);
	end

	// ------------------------------------------------------------
	// global registers and access cycle
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 10; i++) begin
			glb_nxt[i] = glb_r[i];
		end
		if (req && bus.wr && is_gl_rw) begin
			glb_nxt[gl_idx] = bus.wdata;
		end
		chan_nxt = glb_nxt[1][1:0];
	end

	always_comb begin
		rd_val = 8'h00;
		if (is_gl_rw) begin
			rd_val = glb_r[gl_idx];
		end else begin
			unique case (bus.addr)
				`QCR_SVC_SUM: rd_val = svc_sum_i;
				`QCR_RX_VEC: rd_val = bus.svc_act ? rx_vec_i : 8'h00;
				`QCR_TX_VEC: rd_val = bus.svc_act ? tx_vec_i : 8'h00;
				`QCR_MDM_VEC: rd_val = bus.svc_act ? mdm_vec_i : 8'h00;
				`QCR_MDM_STAT: rd_val = bus.svc_act ? mdm_stat_i : 8'h00;
				`QCR_RX_DATA: rd_val = bus.svc_act ? rx_data_i : 8'h00;
				`QCR_CTL_STAT: rd_val = ctl_stat_i[8*chan_r +: 8];
				`QCR_RX_COUNT: rd_val = rx_count_i[8*chan_r +: 8];
				default: rd_val = (kind == qcr_pkg::QCR_KIND_CHANNEL) ? bank_rd[chan_r] : 8'h00;
			endcase
		end
	end

	always_comb begin
		ack_nxt = req;
		rdata_nxt = (req && !bus.wr) ? rd_val : rdata_r;
		txd_nxt = txd_r;
		txs_nxt = 1'b0;
		eos_nxt = 1'b0;
		rstb_nxt = 8'h00;
		if (req && bus.wr && bus.svc_act && bus.addr == `QCR_TX_DATA) begin
			txd_nxt = bus.wdata;
			txs_nxt = 1'b1;
		end
		if (req && bus.wr && bus.svc_act && bus.addr == `QCR_END_SVC) begin
			eos_nxt = 1'b1;
		end
		if (req && !bus.wr && bus.svc_act && bus.addr == `QCR_RX_DATA) begin
			rstb_nxt[chan_r] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 10; i++) begin
				glb_r[i] <= 8'h00;
			end
			chan_r <= 2'b00;
			ack_r <= 1'b0;
			rdata_r <= 8'h00;
			txd_r <= 8'h00;
			txs_r <= 1'b0;
			eos_r <= 1'b0;
			rstb_r <= 8'h00;
		end else begin
			for (int i = 0; i < 10; i++) begin
				glb_r[i] <= glb_nxt[i];
			end
			chan_r <= chan_nxt;
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			txd_r <= txd_nxt;
			txs_r <= txs_nxt;
			eos_r <= eos_nxt;
			rstb_r <= rstb_nxt;
		end
	end

	assign bus.ack = ack_r;
	assign bus.rdata = rdata_r;
	assign chan_sel_o = chan_r;
	assign par_mode_o = glb_r[2][`QCR_GCR_PAR_BIT];
	assign tx_data_o = txd_r;
	assign tx_data_stb_o = txs_r;
	assign end_svc_stb_o = eos_r;
	assign read_stb_o = rstb_r;
endmodule

// ==== hw/qcr_host.sv ====
// host end: classic wishbone slave that runs byte i/o cycles on the decoder link
// assumes: device answers every cycle with ack one edge after cs
`timescale 1ns/100ps
`include "qcr_cfg.svh"
module qcr_host (
	input wire logic clk_i,
	input wire logic rst_i,
	qcr_if.host bus,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o
);
	typedef enum logic [1:0] {QCR_IDLE, QCR_RUN, QCR_DONE} qcr_state_t;
	qcr_state_t st_r, st_nxt;
	logic [6:0] addr_r, addr_nxt;
	logic [7:0] wd_r, wd_nxt, rd_r, rd_nxt;
	logic wr_r, wr_nxt, svc_r, svc_nxt, cs_r, cs_nxt;
	logic [1:0] ist_r, ist_nxt, msk_r, msk_nxt;
	logic ack_r, ack_nxt, irq_nxt, irq_r;
	logic [31:0] dat_r, dat_nxt;
	logic acc;
	assign acc = wb_cyc_i && wb_stb_i && !ack_r;

	always_comb begin
		st_nxt = st_r;
		addr_nxt = addr_r;
		wd_nxt = wd_r;
		wr_nxt = wr_r;
		svc_nxt = svc_r;
		cs_nxt = cs_r;
		rd_nxt = rd_r;
		ist_nxt = ist_r;
		msk_nxt = msk_r;
		ack_nxt = 1'b0;
		dat_nxt = dat_r;
		if (acc) begin
			ack_nxt = 1'b1;
			dat_nxt = 32'h0000_0000;
			unique case ({wb_adr_i[4:2], 2'b00})
				`QCR_WB_ADDR: begin
					if (wb_we_i && wb_sel_i[0]) addr_nxt = wb_dat_i[6:0];
					dat_nxt = {25'h0, addr_r};
				end
				`QCR_WB_WDATA: begin
					if (wb_we_i && wb_sel_i[0]) wd_nxt = wb_dat_i[7:0];
					dat_nxt = {24'h0, wd_r};
				end
				`QCR_WB_CMD: begin
					if (wb_we_i && wb_sel_i[0] && st_r == QCR_IDLE && wb_dat_i[0]) begin
						wr_nxt = wb_dat_i[1];
						cs_nxt = 1'b1;
						st_nxt = QCR_RUN;
					end
					if (wb_we_i && wb_sel_i[0]) svc_nxt = wb_dat_i[2];
					dat_nxt = {29'h0, svc_r, wr_r, 1'b0};
				end
				`QCR_WB_RDATA: dat_nxt = {24'h0, rd_r};
				`QCR_WB_IRQ_ST: begin
					if (wb_we_i && wb_sel_i[0]) ist_nxt = ist_r & ~wb_dat_i[1:0];
					dat_nxt = {30'h0, ist_r};
				end
				`QCR_WB_IRQ_MSK: begin
					if (wb_we_i && wb_sel_i[0]) msk_nxt = wb_dat_i[1:0];
					dat_nxt = {30'h0, msk_r};
				end
				`QCR_WB_STATUS: dat_nxt = {31'h0, st_r != QCR_IDLE};
				default: dat_nxt = 32'h0000_0000;
			endcase
		end
		unique case (st_r)
			QCR_IDLE: ;
			QCR_RUN: begin
				if (bus.ack) begin
					cs_nxt = 1'b0;
					if (!wr_r) rd_nxt = bus.rdata;
					st_nxt = QCR_DONE;
				end
			end
			QCR_DONE: begin
				// set wins over a same-cycle clear
				if (wr_r) ist_nxt[1] = 1'b1;
				else ist_nxt[0] = 1'b1;
				st_nxt = QCR_IDLE;
			end
		endcase
		irq_nxt = |(ist_nxt & msk_nxt);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= QCR_IDLE;
			addr_r <= 7'h00;
			wd_r <= 8'h00;
			wr_r <= 1'b0;
			svc_r <= 1'b0;
			cs_r <= 1'b0;
			rd_r <= 8'h00;
			ist_r <= 2'b00;
			msk_r <= 2'b00;
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
			irq_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			addr_r <= addr_nxt;
			wd_r <= wd_nxt;
			wr_r <= wr_nxt;
			svc_r <= svc_nxt;
			cs_r <= cs_nxt;
			rd_r <= rd_nxt;
			ist_r <= ist_nxt;
			msk_r <= msk_nxt;
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign bus.cs = cs_r;
	assign bus.wr = wr_r;
	assign bus.addr = addr_r;
	assign bus.wdata = wd_r;
	assign bus.svc_act = svc_r;
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign irq_o = irq_r;
endmodule

// ==== hw/qcr_if.sv ====
// byte-wide i/o cycle link between host and register decoder
// assumes: one clock shared by both ends
`timescale 1ns/100ps
interface qcr_if;
	logic cs;
	logic wr;
	qcr_pkg::qcr_addr_t addr;
	qcr_pkg::qcr_byte_t wdata;
	qcr_pkg::qcr_byte_t rdata;
	logic ack;
	logic svc_act;
	modport dev (input cs, input wr, input addr, input wdata, input svc_act, output rdata, output ack);
	modport host (output cs, output wr, output addr, output wdata, output svc_act, input rdata, input ack);
endinterface

// ==== hw/qcr_pkg.sv ====
// types shared by both ends of the quad channel register decoder
// assumes: qcr_cfg.svh alongside
package qcr_pkg;
	typedef logic [6:0] qcr_addr_t;
	typedef logic [7:0] qcr_byte_t;
	typedef logic [1:0] qcr_chan_t;
	typedef enum logic [1:0] {QCR_KIND_NONE, QCR_KIND_GLOBAL, QCR_KIND_VIRTUAL, QCR_KIND_CHANNEL} qcr_kind_t;
endpackage

// ==== testbench/qcr_link_monitor.sv ====
// concurrent checks on the byte link between the host end and the device end
// assumes: instantiated beside the link interface; one clock, synchronous reset
`timescale 1ns/100ps
module qcr_link_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cs,
	input wire logic wr,
	input wire qcr_pkg::qcr_addr_t addr,
	input wire qcr_pkg::qcr_byte_t wdata,
	input wire qcr_pkg::qcr_byte_t rdata,
	input wire logic ack,
	input wire logic svc_act
);
	// ----------------------------------------
	// shadow of values written over the link
	// ----------------------------------------
	logic [7:0] sel_r;
	logic [7:0] glob_r;
	logic [7:0] bank_r [4];
	logic rd_ack;
	assign rd_ack = ack && !wr;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_r <= 8'h00;
			glob_r <= 8'h00;
			bank_r <= '{default: 8'h00};
		end else if (ack && wr) begin
			if (addr == 7'h68)
				sel_r <= wdata;
			if (addr == 7'h44)
				glob_r <= wdata;
			if (addr == 7'h06)
				bank_r[sel_r[1:0]] <= wdata;
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	ack_follow_a: assert property (cs && !ack |=> ack) else $error("request not answered next cycle");
	ack_pulse_a: assert property (ack |=> !ack) else $error("answer longer than one cycle");
	ack_cause_a: assert property ($rose(ack) |-> $past(cs)) else $error("answer without request");
	req_hold_a: assert property (cs && !ack |=> cs && $stable(addr) && $stable(wr) && $stable(wdata))
		else $error("request changed before answer");
	cs_drop_a: assert property (ack |=> !cs) else $error("request kept after answer");
	wr_keep_a: assert property (ack && wr |-> $stable(rdata)) else $error("read data moved on a write");
	virt_hidden_a: assert property (rd_ack && !svc_act &&
		addr inside {7'h41, 7'h42, 7'h43, 7'h62, 7'h4C} |-> rdata == 8'h00)
		else $error("virtual register seen outside service");
	unmapped_zero_a: assert property (rd_ack && addr == 7'h7F |-> rdata == 8'h00)
		else $error("unmapped read not zero");
	sel_back_a: assert property (rd_ack && addr == 7'h68 |-> rdata == sel_r)
		else $error("channel select lost");
	glob_back_a: assert property (rd_ack && addr == 7'h44 |-> rdata == glob_r)
		else $error("global value lost");
	bank_back_a: assert property (rd_ack && addr == 7'h06 |-> rdata == bank_r[sel_r[1:0]])
		else $error("bank value from wrong channel");
endmodule

// ==== testbench/tb_quad_channel_register_decode.sv ====
// self-checking bench: a wishbone master drives the host end, which runs link cycles to the device end
// assumes: qcr_pkg compiled first, qcr_cfg.svh on the include path
`timescale 1ns/100ps
`include "qcr_cfg.svh"
module tb_quad_channel_register_decode;
	typedef struct packed {logic [6:0] a; logic s; logic [7:0] d; logic [7:0] v; logic [7:0] e;} qcr_row_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [4:0] wb_adr = 5'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_wdat = 32'h0, wb_rdat;
	logic wb_ack, irq, par_mode, tx_stb, eos_stb;
	logic [1:0] chan_sel;
	logic [7:0] sv = 8'h00, tx_data, read_stb, rd, rs_seen = 8'h00;
	logic [31:0] q;
	int n_errors = 0, check_count = 0, n_eos = 0, n_tx = 0;
	qcr_row_t rows [23] = '{
		'{7'h44, 1'b0, 8'hA5, 8'h00, 8'hA5}, '{7'h45, 1'b0, 8'h3C, 8'h00, 8'h3C},
		'{7'h46, 1'b1, 8'hC3, 8'h00, 8'hC3}, '{7'h05, 1'b0, 8'h11, 8'h00, 8'h11},
		'{7'h06, 1'b0, 8'hEE, 8'h00, 8'hEE}, '{7'h6C, 1'b0, 8'h6C, 8'h00, 8'h6C},
		'{7'h6D, 1'b0, 8'hD6, 8'h00, 8'hD6}, '{7'h6F, 1'b0, 8'hF6, 8'h00, 8'hF6},
		'{7'h72, 1'b0, 8'h27, 8'h00, 8'h27}, '{7'h76, 1'b0, 8'h67, 8'h00, 8'h67},
		'{7'h78, 1'b0, 8'h87, 8'h00, 8'h87}, '{7'h7C, 1'b0, 8'hC7, 8'h00, 8'hC7},
		'{7'h43, 1'b1, 8'hFF, 8'h12, 8'h12}, '{7'h42, 1'b1, 8'hFF, 8'h12, 8'hED},
		'{7'h41, 1'b1, 8'hFF, 8'h12, 8'h1D}, '{7'h43, 1'b0, 8'hFF, 8'h12, 8'h00},
		'{7'h62, 1'b1, 8'hFF, 8'h12, 8'h21}, '{7'h4C, 1'b1, 8'hFF, 8'h12, 8'hE2},
		'{7'h67, 1'b0, 8'hFF, 8'h12, 8'hDE}, '{7'h0B, 1'b0, 8'hFF, 8'h12, 8'h12},
		'{7'h0E, 1'b0, 8'hFF, 8'h12, 8'h52}, '{7'h7F, 1'b0, 8'hFF, 8'h12, 8'h00},
		'{7'h60, 1'b1, 8'hFF, 8'h12, 8'h00}};
	always #2.5 clk_i = ~clk_i;
	qcr_if link();
	qcr_dev qcr_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(link), .rx_vec_i(sv), .tx_vec_i(sv ^ 8'hFF),
		.mdm_vec_i(sv ^ 8'h0F), .mdm_stat_i(sv ^ 8'hF0), .rx_data_i(sv ^ 8'h33), .svc_sum_i(sv ^ 8'hCC),
		.ctl_stat_i({4{sv}} ^ 32'h03020100), .rx_count_i({4{sv}} ^ 32'h30201040), .chan_sel_o(chan_sel),
		.par_mode_o(par_mode), .tx_data_o(tx_data), .tx_data_stb_o(tx_stb), .end_svc_stb_o(eos_stb),
		.read_stb_o(read_stb));
	qcr_host qcr_host_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(link), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack), .irq_o(irq));
	qcr_link_monitor qcr_link_monitor_inst (.clk_i(clk_i), .rst_i(rst_i), .cs(link.cs), .wr(link.wr),
		.addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .svc_act(link.svc_act));
	always @(posedge clk_i) begin
		if (!rst_i && eos_stb === 1'b1)
			n_eos <= n_eos + 1;
		if (!rst_i && tx_stb === 1'b1)
			n_tx <= n_tx + 1;
		if (!rst_i)
			rs_seen <= rs_seen | read_stb;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
		int i;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdat <= d;
		wb_sel <= 4'h1;
		i = 0;
		// request stands until the rising edge that samples ack high
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack !== 1'b1 && i < 50);
		r = wb_rdat;
		if (wb_ack !== 1'b1) begin
			n_errors++;
			$display("wrong value at %0t: bus answer timed out", $time);
			end_sim();
		end else begin
			wb_cyc <= 1'b0;
			wb_stb <= 1'b0;
		end
	endtask
	task automatic lk(input logic w, input logic s, input logic [6:0] a, input logic [7:0] d, output logic [7:0] r);
		logic [31:0] x;
		int i;
		wb(1'b1, 5'(`QCR_WB_ADDR), {25'h0, a}, x);
		wb(1'b1, 5'(`QCR_WB_WDATA), {24'h0, d}, x);
		wb(1'b1, 5'(`QCR_WB_CMD), {29'h0, s, w, 1'b1}, x);
		i = 0;
		do begin
			wb(1'b0, `QCR_WB_STATUS, 32'h0, x);
			i++;
		end while (x[0] !== 1'b0 && i < 20);
		chk(x[0], 1'b0);
		if (x[0] !== 1'b0) begin
			end_sim();
		end else begin
			wb(1'b0, 5'(`QCR_WB_RDATA), 32'h0, x);
			r = x[7:0];
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(chan_sel, 2'd0);
		chk(irq, 1'b0);
		chk(par_mode, 1'b0);
		lk(1'b0, 1'b0, 7'h68, 8'h00, rd);
		chk(rd, 8'h00);
		$display("test reset done");
		foreach (rows[k]) begin
			sv <= rows[k].v;
			lk(1'b1, rows[k].s, rows[k].a, rows[k].d, rd);
			lk(1'b0, rows[k].s, rows[k].a, 8'h00, rd);
			chk(rd, rows[k].e);
		end
		$display("test register table done");
		lk(1'b1, 1'b0, 7'h68, 8'h01, rd);
		lk(1'b1, 1'b0, 7'h06, 8'hA5, rd);
		lk(1'b1, 1'b0, 7'h68, 8'h02, rd);
		lk(1'b1, 1'b0, 7'h06, 8'h5A, rd);
		lk(1'b1, 1'b0, 7'h44, 8'h77, rd);
		chk(chan_sel, 2'd2);
		sv <= 8'h40;
		lk(1'b0, 1'b0, 7'h0B, 8'h00, rd);
		chk(rd, 8'h42);
		lk(1'b1, 1'b0, 7'h68, 8'h01, rd);
		lk(1'b0, 1'b0, 7'h06, 8'h00, rd);
		chk(rd, 8'hA5);
		lk(1'b0, 1'b0, 7'h44, 8'h00, rd);
		chk(rd, 8'h77);
		lk(1'b1, 1'b0, 7'h68, 8'h06, rd);
		chk(chan_sel, 2'd2);
		lk(1'b0, 1'b0, 7'h06, 8'h00, rd);
		chk(rd, 8'h5A);
		lk(1'b0, 1'b0, 7'h68, 8'h00, rd);
		chk(rd, 8'h06);
		lk(1'b1, 1'b0, 7'h68, 8'h00, rd);
		$display("test bank switch done");
		lk(1'b1, 1'b1, 7'h63, 8'h9A, rd);
		chk(tx_data, 8'h9A);
		lk(1'b1, 1'b0, 7'h63, 8'h11, rd);
		chk(tx_data, 8'h9A);
		chk(n_tx, 1);
		lk(1'b1, 1'b0, 7'h60, 8'h00, rd);
		chk(n_eos, 1);
		chk(rs_seen, 8'h01);
		lk(1'b1, 1'b0, 7'h4B, 8'h80, rd);
		chk(par_mode, 1'b1);
		lk(1'b1, 1'b0, 7'h4B, 8'h7F, rd);
		chk(par_mode, 1'b0);
		$display("test virtual and mode done");
		wb(1'b1, `QCR_WB_IRQ_ST, 32'h3, q);
		wb(1'b1, `QCR_WB_IRQ_MSK, 32'h1, q);
		chk(irq, 1'b0);
		lk(1'b0, 1'b0, 7'h05, 8'h00, rd);
		chk(irq, 1'b1);
		wb(1'b0, `QCR_WB_IRQ_ST, 32'h0, q);
		chk(q, 32'h1);
		wb(1'b1, `QCR_WB_IRQ_ST, 32'h1, q);
		wb(1'b0, `QCR_WB_IRQ_ST, 32'h0, q);
		chk(q, 32'h0);
		chk(irq, 1'b0);
		lk(1'b1, 1'b0, 7'h05, 8'h00, rd);
		wb(1'b0, `QCR_WB_IRQ_ST, 32'h0, q);
		chk(q, 32'h2);
		chk(irq, 1'b0);
		wb(1'b0, 5'h1C, 32'h0, q);
		chk(q, 32'h0);
		$display("test interrupt and unmapped done");
		lk(1'b1, 1'b0, 7'h68, 8'h03, rd);
		chk(chan_sel, 2'd3);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(chan_sel, 2'd0);
		wb(1'b0, `QCR_WB_IRQ_ST, 32'h0, q);
		chk(q, 32'h0);
		lk(1'b0, 1'b0, 7'h44, 8'h00, rd);
		chk(rd, 8'h00);
		chk(irq, 1'b0);
		$display("test mid-run reset done");
		end_sim();
	end
endmodule
